// ===== hw/err_check_pkg.sv
// package: error codes, modes, event carriers and timing constants for the error checker
package err_check_pkg;

  // operating modes of the controller
  typedef enum logic [1:0] {MODE_RUN, MODE_PROG, MODE_LOAD} op_mode_t;

  // two-digit error codes, bcd coded
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_BAD_OP = 8'h01;
  localparam logic [7:0] CODE_STACK = 8'h03;
  localparam logic [7:0] CODE_DUP_COIL = 8'h05;
  localparam logic [7:0] CODE_MC_OPEN = 8'h06;
  localparam logic [7:0] CODE_NO_PRESET = 8'h08;
  localparam logic [7:0] CODE_OPEN_RUNG = 8'h09;
  localparam logic [7:0] CODE_MEM_FULL = 8'h11;
  localparam logic [7:0] CODE_HSC_MANY = 8'h13;
  localparam logic [7:0] CODE_PARITY = 8'h21;
  localparam logic [7:0] CODE_CMP_FAIL = 8'h25;
  localparam logic [7:0] CODE_WEAK_SIG = 8'h28;
  localparam logic [7:0] CODE_LINK_LOST = 8'h30;
  localparam logic [7:0] CODE_LINK_FRAME = 8'h31;
  localparam logic [7:0] CODE_LINK_PAR = 8'h32;
  localparam logic [7:0] CODE_NO_RESP = 8'h33;
  localparam logic [7:0] CODE_SEARCH_MISS = 8'h99;

  // program memory geometry
  localparam int ADDR_W = 11;
  localparam logic [10:0] ADDR_ZERO = 11'h000;
  localparam logic [10:0] ADDR_LAST = 11'h7FF;

  // stack depth limit and preset point limit
  localparam logic [3:0] STACK_MAX = 4'h8;
  localparam logic [5:0] HSC_MAX = 6'h14;

  // power-up configuration answer timeout
  localparam int CFG_WAIT_US = 100;
  localparam int CLK_MHZ = 125;
  localparam int CFG_WAIT_CYC = CFG_WAIT_US * CLK_MHZ;

  // one decoded program word presented by the scanner
  typedef struct packed {
    logic valid;       // word present this cycle
    logic last;        // final word of program
    logic [10:0] addr; // word address
    logic is_start;    // rung start contact
    logic is_push;     // pushes a status level
    logic is_coil;     // coil output
    logic [9:0] coil_ref; // coil reference number
    logic needs_preset; // timer/counter/shift stage
    logic has_preset;  // preset value present
    logic mc_begin;    // master control begin
    logic mc_end;      // master control end
    logic rung_open;   // contacts not tied to a coil at rung end
    logic parity_bad;  // stored word parity fault
  } prog_word_t;

  // programmer key events, one-cycle pulses
  typedef struct packed {
    logic clear_key;   // acknowledge
    logic enter;       // function entry
    logic bad_seq;     // wrong key sequence
    logic bad_range;   // reference out of range
    logic modify;      // attempt to alter program
    logic mem_full;    // memory at capacity on add
    logic hsc_preset;  // high-speed counter preset point entry
    logic search_key;  // start search
  } key_evt_t;

  // expansion rack and tape events
  typedef struct packed {
    logic link_lost;   // rack communication lost
    logic frame_err;   // rack framing error
    logic par_err;     // rack parity error
    logic cfg_answer;  // rack answered config request
    logic tape_word;   // verify word arrived
    logic [15:0] tape_data; // verify word
    logic weak_sig;    // playback level below threshold
  } ext_evt_t;

endpackage

// ===== hw/plc_program_error_checker.sv
// error checker: validates keys and stored program, reports two-digit error codes
`timescale 1ns/1ps
`default_nettype none

module plc_program_error_checker #(
  parameter int CFG_WAIT = err_check_pkg::CFG_WAIT_CYC
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire err_check_pkg::op_mode_t mode_in,
  input wire err_check_pkg::key_evt_t key_in,
  input wire err_check_pkg::prog_word_t word_in,
  input wire logic [15:0] mem_rd_data_in,
  input wire logic search_hit_in,
  input wire logic search_wrap_in,
  input wire err_check_pkg::ext_evt_t ext_in,
  output logic scan_req_out,
  output logic [10:0] scan_addr_out,
  output logic [10:0] verify_addr_out,
  output logic err_show_out,
  output logic [7:0] err_code_out,
  output logic [10:0] err_addr_out,
  output logic run_halt_out,
  output logic outputs_off_out,
  output logic enter_ok_out,
  output logic mem_wr_en_out
);

  // scan sequencer states
  typedef enum logic [1:0] {SC_IDLE, SC_WALK, SC_DONE} scan_state_t;

  // registers, next state and combinational findings
  scan_state_t scan_st_r, scan_st_nxt;       // program check sequencer
  err_check_pkg::op_mode_t mode_prev_r;      // mode last cycle
  logic [10:0] scan_addr_r;                  // word being requested
  logic [3:0] stack_r;                       // status levels in use
  logic [7:0] mc_depth_r;                    // open master control blocks
  logic [1023:0] coil_seen_r;                // coils already used as output
  logic [5:0] hsc_cnt_r;                     // preset points entered
  logic [10:0] verify_addr_r;                // verify compare pointer
  logic [13:0] cfg_cnt_r;                    // power-up answer timer
  logic cfg_wait_r;                          // still waiting for rack answer
  logic halt_r;                              // execution stopped by link fault
  logic show_r;                              // error latched on display
  logic [7:0] code_r;                        // displayed code
  logic [10:0] eaddr_r;                      // faulty logic address
  logic enter_ok_r;                          // accepted entry pulse
  logic scan_req_r;                          // walk in progress, registered for the port
  logic [7:0] scan_code;                     // program check finding
  logic [7:0] key_code;                      // operator finding
  logic [7:0] ext_code;                      // link and tape finding
  logic [7:0] new_code;                      // highest priority finding
  logic [10:0] new_addr;                     // address shown with finding

  // mode helpers; the mode switch comes from logic on this clock, so it is
  // read directly, and run entry shows one edge after the switch moves
  wire in_run = (mode_in == err_check_pkg::MODE_RUN);
  wire in_prog = (mode_in == err_check_pkg::MODE_PROG);
  wire in_load = (mode_in == err_check_pkg::MODE_LOAD);
  wire to_run = in_run && (mode_prev_r != err_check_pkg::MODE_RUN);

  // program word checks, only while walking in run; a word that arrives in
  // the cycle the switch leaves run is dropped, so these codes stay in run
  wire walk = (scan_st_r == SC_WALK) && word_in.valid && in_run;
  wire stack_ovf = walk && word_in.is_push && (stack_r == err_check_pkg::STACK_MAX);
  wire dup_coil = walk && word_in.is_coil && coil_seen_r[word_in.coil_ref];
  wire mc_over = walk && word_in.mc_end && (mc_depth_r == 8'h00);
  wire no_preset = walk && word_in.needs_preset && !word_in.has_preset;
  wire open_rung = walk && word_in.rung_open;
  wire par_bad = walk && word_in.parity_bad;

  // program check finding by priority
  // only one finding is kept per word; the walk stops on it, so a lower
  // ranked fault in the same word shows up after it has been repaired
  always_comb begin
    if (par_bad) begin
      scan_code = err_check_pkg::CODE_PARITY;
    end else if (stack_ovf) begin
      scan_code = err_check_pkg::CODE_STACK;
    end else if (dup_coil) begin
      scan_code = err_check_pkg::CODE_DUP_COIL;
    end else if (mc_over) begin
      scan_code = err_check_pkg::CODE_MC_OPEN;
    end else if (no_preset) begin
      scan_code = err_check_pkg::CODE_NO_PRESET;
    end else if (open_rung) begin
      scan_code = err_check_pkg::CODE_OPEN_RUNG;
    end else begin
      scan_code = err_check_pkg::CODE_NONE;
    end
  end

  // operator key checks
  // memory full only counts as an attempt when it comes with an entry
  // search miss needs both the wrap flag and no hit on the same strobe
  wire bad_op = (key_in.modify && in_run) || key_in.bad_seq || key_in.bad_range;
  wire full_add = key_in.mem_full && key_in.enter && in_prog;
  wire hsc_over = key_in.hsc_preset && in_prog && (hsc_cnt_r == err_check_pkg::HSC_MAX);
  wire miss = key_in.search_key && search_wrap_in && !search_hit_in && (in_run || in_prog);

  // operator finding by priority
  always_comb begin
    if (bad_op) begin
      key_code = err_check_pkg::CODE_BAD_OP;
    end else if (full_add) begin
      key_code = err_check_pkg::CODE_MEM_FULL;
    end else if (hsc_over) begin
      key_code = err_check_pkg::CODE_HSC_MANY;
    end else if (miss) begin
      key_code = err_check_pkg::CODE_SEARCH_MISS;
    end else begin
      key_code = err_check_pkg::CODE_NONE;
    end
  end

  // verify compare: read only, no write path exists
  wire cmp_bad = in_load && ext_in.tape_word && (ext_in.tape_data != mem_rd_data_in);
  // the timer fires once, on the last cycle of the wait window; an answer
  // that lands in that very cycle still counts as an answer
  wire cfg_miss = cfg_wait_r && (cfg_cnt_r == 14'(CFG_WAIT - 1)) && !ext_in.cfg_answer;

  // link and tape finding, each in its listed mode
  // the no-answer code belongs to run only; outside run the wait ends silently
  always_comb begin
    if (ext_in.link_lost && in_prog) begin
      ext_code = err_check_pkg::CODE_LINK_LOST;
    end else if (ext_in.frame_err && in_run) begin
      ext_code = err_check_pkg::CODE_LINK_FRAME;
    end else if (ext_in.par_err && in_run) begin
      ext_code = err_check_pkg::CODE_LINK_PAR;
    end else if (cfg_miss && in_run) begin
      ext_code = err_check_pkg::CODE_NO_RESP;
    end else if (cmp_bad) begin
      ext_code = err_check_pkg::CODE_CMP_FAIL;
    end else if (ext_in.weak_sig && in_load) begin
      ext_code = err_check_pkg::CODE_WEAK_SIG;
    end else begin
      ext_code = err_check_pkg::CODE_NONE;
    end
  end

  // overall selection: link and tape faults, program check, operator
  always_comb begin
    if (ext_code != err_check_pkg::CODE_NONE) begin
      new_code = ext_code;
      new_addr = verify_addr_r;
    end else if (scan_code != err_check_pkg::CODE_NONE) begin
      new_code = scan_code;
      new_addr = word_in.addr;
    end else begin
      new_code = key_code;
      new_addr = scan_addr_r;
    end
  end

  // faults that stop execution and switch the outputs off
  wire link_fault = (ext_code == err_check_pkg::CODE_LINK_LOST) ||
                    (ext_code == err_check_pkg::CODE_LINK_FRAME) ||
                    (ext_code == err_check_pkg::CODE_LINK_PAR);
  // the walk ends at its first finding or at the last word
  wire scan_stop = (scan_code != err_check_pkg::CODE_NONE) || (walk && word_in.last);

  // sequencer next state
  // the walk waits in done until the switch leaves run: one entry, one check
  always_comb begin
    case (scan_st_r)
      SC_IDLE: scan_st_nxt = to_run ? SC_WALK : SC_IDLE;
      SC_WALK: scan_st_nxt = (!in_run || scan_stop) ? SC_DONE : SC_WALK;
      SC_DONE: scan_st_nxt = in_run ? SC_DONE : SC_IDLE;
      default: scan_st_nxt = SC_IDLE;
    endcase
  end

  // sequencer and mode history
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_st_r <= SC_IDLE;
      mode_prev_r <= err_check_pkg::MODE_PROG;
    end else begin
      scan_st_r <= scan_st_nxt;
      mode_prev_r <= mode_in;
    end
  end

  // scan address and structure counters
  // a rung start contact opens a fresh stack; pushes past the limit saturate
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_addr_r <= err_check_pkg::ADDR_ZERO;
      stack_r <= 4'h0;
      mc_depth_r <= 8'h00;
    end else if (scan_st_r != SC_WALK) begin
      scan_addr_r <= err_check_pkg::ADDR_ZERO;
      stack_r <= 4'h0;
      mc_depth_r <= 8'h00;
    end else if (walk) begin
      scan_addr_r <= scan_addr_r + 11'h001;
      if (word_in.is_start) begin
        stack_r <= 4'h0;
      end else if (word_in.is_push && stack_r != err_check_pkg::STACK_MAX) begin
        stack_r <= stack_r + 4'h1;
      end
      if (word_in.mc_begin) begin
        mc_depth_r <= mc_depth_r + 8'h01;
      end else if (word_in.mc_end && mc_depth_r != 8'h00) begin
        mc_depth_r <= mc_depth_r - 8'h01;
      end
    end
  end

  // coil usage map
  // the map is wiped whenever no walk runs, so each run entry starts clean
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      coil_seen_r <= '0;
    end else if (scan_st_r != SC_WALK) begin
      coil_seen_r <= '0;
    end else if (walk && word_in.is_coil) begin
      coil_seen_r[word_in.coil_ref] <= 1'b1;
    end
  end

  // preset point count and verify pointer
  // the point count is cleared only by reset, never by a mode change
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hsc_cnt_r <= 6'h00;
      verify_addr_r <= err_check_pkg::ADDR_ZERO;
    end else begin
      if (key_in.hsc_preset && in_prog && hsc_cnt_r != err_check_pkg::HSC_MAX) begin
        hsc_cnt_r <= hsc_cnt_r + 6'h01;
      end
      if (!in_load) begin
        verify_addr_r <= err_check_pkg::ADDR_ZERO;
      end else if (ext_in.tape_word) begin
        verify_addr_r <= verify_addr_r + 11'h001;
      end
    end
  end

  // power-up configuration answer watch
  // the timer runs once after reset and stops on an answer or on expiry
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_wait_r <= 1'b1;
      cfg_cnt_r <= 14'h0000;
    end else if (cfg_wait_r) begin
      cfg_cnt_r <= cfg_cnt_r + 14'h0001;
      if (ext_in.cfg_answer || cfg_miss) begin
        cfg_wait_r <= 1'b0;
      end
    end
  end

  // halt on link fault until the switch next enters run
  // a fault in the same cycle as the return to run keeps the halt
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      halt_r <= 1'b0;
    end else if (link_fault) begin
      halt_r <= 1'b1;
    end else if (to_run) begin
      halt_r <= 1'b0;
    end
  end

  // displayed error latch, new error wins over clear
  // the address is kept on clear so the operator can still look it up
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      show_r <= 1'b0;
      code_r <= err_check_pkg::CODE_NONE;
      eaddr_r <= err_check_pkg::ADDR_ZERO;
    end else if (new_code != err_check_pkg::CODE_NONE) begin
      show_r <= 1'b1;
      code_r <= new_code;
      eaddr_r <= new_addr;
    end else if (key_in.clear_key) begin
      show_r <= 1'b0;
      code_r <= err_check_pkg::CODE_NONE;
    end
  end

  // accepted entry pulse
  // a refused entry leaves memory untouched and only shows its code
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enter_ok_r <= 1'b0;
    end else begin
      enter_ok_r <= key_in.enter && in_prog && !bad_op && !full_add && !hsc_over;
    end
  end

  // walk flag for the port, taken from the next state so it rises with the walk
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_req_r <= 1'b0;
    end else begin
      scan_req_r <= (scan_st_nxt == SC_WALK);
    end
  end

  // outputs, each straight from a flop
  assign scan_req_out = scan_req_r;
  assign scan_addr_out = scan_addr_r;
  assign verify_addr_out = verify_addr_r;
  assign err_show_out = show_r;
  assign err_code_out = code_r;
  assign err_addr_out = eaddr_r;
  assign run_halt_out = halt_r;
  // halt and outputs off share one flop so they can never disagree
  assign outputs_off_out = halt_r;
  assign enter_ok_out = enter_ok_r;
  // memory is written only by an accepted entry, which needs program mode
  assign mem_wr_en_out = enter_ok_r;

endmodule // plc_program_error_checker

`default_nettype wire

// ===== tb/err_check_sva.sv
// concurrent checks on the error checker ports
`timescale 1ns/1ps
`default_nettype none
module err_check_sva (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire err_check_pkg::op_mode_t mode_in,
  input wire err_check_pkg::key_evt_t key_in,
  input wire err_check_pkg::prog_word_t word_in,
  input wire logic [15:0] mem_rd_data_in,
  input wire logic search_hit_in,
  input wire logic search_wrap_in,
  input wire err_check_pkg::ext_evt_t ext_in,
  input wire logic scan_req_out,
  input wire logic [10:0] scan_addr_out,
  input wire logic [10:0] verify_addr_out,
  input wire logic err_show_out,
  input wire logic [7:0] err_code_out,
  input wire logic [10:0] err_addr_out,
  input wire logic run_halt_out,
  input wire logic outputs_off_out,
  input wire logic enter_ok_out,
  input wire logic mem_wr_en_out
);
  wire logic in_run = (mode_in == err_check_pkg::MODE_RUN); // run selected
  wire logic in_prog = (mode_in == err_check_pkg::MODE_PROG); // program selected
  wire logic in_load = (mode_in == err_check_pkg::MODE_LOAD); // load selected
  // no partner event and no program word this cycle
  wire logic quiet = (ext_in[21:17] == 5'h00) && !ext_in.weak_sig && !word_in.valid;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_verify_read_only: assert property (in_load && !key_in.enter |=> !mem_wr_en_out)
    else $error("memory written during verify");
  a_cmp_fail_code: assert property (in_load && ext_in.tape_word &&
    ext_in.tape_data != mem_rd_data_in |=> err_show_out && err_code_out == 8'h25)
    else $error("verify mismatch not reported");
  a_code_bcd_form: assert property (err_show_out |-> err_code_out != 8'h00 &&
    err_code_out[7:4] <= 4'h9 && err_code_out[3:0] <= 4'h9)
    else $error("shown code not two decimal digits");
  a_check_on_run: assert property (in_run && $past(mode_in) != err_check_pkg::MODE_RUN
    |=> scan_req_out)
    else $error("program check not started on run entry");
  a_entry_gate: assert property (enter_ok_out |-> $past(key_in.enter) &&
    !$past(key_in.bad_seq) && !$past(key_in.bad_range))
    else $error("bad entry accepted");
  a_lost_halt: assert property (in_prog && ext_in.link_lost |=> run_halt_out &&
    outputs_off_out && err_code_out == 8'h30)
    else $error("lost link not halting");
  a_frame_halt: assert property (in_run && ext_in.frame_err |=> run_halt_out &&
    outputs_off_out && err_code_out == 8'h31)
    else $error("framing fault not halting");
  a_parity_halt: assert property (in_run && ext_in.par_err && !ext_in.frame_err |=>
    run_halt_out && err_code_out == 8'h32)
    else $error("link parity fault not halting");
  a_clear_ack: assert property (key_in == 8'h80 && quiet |=> !err_show_out)
    else $error("clear did not acknowledge");
  a_full_prog_only: assert property ($changed(err_code_out) && err_code_out == 8'h11
    |-> $past(mode_in) == err_check_pkg::MODE_PROG)
    else $error("memory full outside program mode");
  a_code_latched: assert property (err_show_out && key_in == 8'h00 && quiet &&
    $stable(mode_in) |=> err_show_out && $stable(err_code_out))
    else $error("error code dropped");
endmodule // err_check_sva
bind plc_program_error_checker err_check_sva u_err_check_sva (
  .mclk_in, .arst_n_in, .mode_in, .key_in, .word_in, .mem_rd_data_in, .search_hit_in,
  .search_wrap_in, .ext_in, .scan_req_out, .scan_addr_out, .verify_addr_out, .err_show_out,
  .err_code_out, .err_addr_out, .run_halt_out, .outputs_off_out, .enter_ok_out, .mem_wr_en_out
);
`default_nettype wire

// ===== tb/rack_tape_model.sv
// partner model: expansion rack link and tape verify source
`timescale 1ns/1ps
`default_nettype none
module rack_tape_model #(
  parameter int ANS_DLY = 5
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] evt_in,
  input wire logic corrupt_in,
  input wire logic mute_in,
  output var err_check_pkg::ext_evt_t ext_out
);
  logic [7:0] up_cnt_r; // cycles since power-up, saturating
  logic [10:0] tape_ptr_r; // index of next tape word
  // power-up timer and tape position
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt_r <= 8'h00;
      tape_ptr_r <= 11'h000;
    end else begin
      if (up_cnt_r != 8'hFF) up_cnt_r <= up_cnt_r + 8'h01;
      if (evt_in[1]) tape_ptr_r <= tape_ptr_r + 11'h001;
    end
  end
  // one config answer after power-up unless muted; tape mirrors memory, idle inverse
  assign ext_out = '{link_lost: evt_in[4], frame_err: evt_in[3], par_err: evt_in[2],
    cfg_answer: !mute_in && (up_cnt_r == 8'(ANS_DLY)), tape_word: evt_in[1],
    weak_sig: evt_in[0],
    tape_data: evt_in[1] ? ({5'h15, tape_ptr_r} ^ {15'h0000, corrupt_in})
      : ~{5'h15, tape_ptr_r}};
endmodule // rack_tape_model
`default_nettype wire

// ===== tb/tb.sv
// testbench: keys, program words and partner events against error codes
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_in = 1'b0; // 125 MHz clock
  logic arst_n_in = 1'b0; // reset, active low
  err_check_pkg::op_mode_t mode = err_check_pkg::MODE_PROG; // mode switch
  err_check_pkg::key_evt_t key = '0; // key pulses
  err_check_pkg::prog_word_t word = '0; // scanner word
  err_check_pkg::ext_evt_t ext; // partner events
  logic [4:0] evt = 5'h00; // partner commands
  logic corrupt = 1'b0; // tape fault select
  logic mute = 1'b0; // rack stays silent after reset
  logic hit = 1'b0; // search match
  logic wrap = 1'b0; // search wrapped
  logic scan_req, err_show, halt, off, enter_ok, wr_en; // design flags
  logic [10:0] scan_addr, verify_addr, err_addr; // design pointers
  logic [7:0] err_code; // shown code
  int n_errors = 0;
  int cmp_count = 0;
  always #4 mclk_in = ~mclk_in;
  plc_program_error_checker #(.CFG_WAIT(20)) u_plc_program_error_checker (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .mode_in(mode), .key_in(key), .word_in(word),
    .mem_rd_data_in({5'h15, verify_addr}), .search_hit_in(hit), .search_wrap_in(wrap),
    .ext_in(ext), .scan_req_out(scan_req), .scan_addr_out(scan_addr),
    .verify_addr_out(verify_addr), .err_show_out(err_show), .err_code_out(err_code),
    .err_addr_out(err_addr), .run_halt_out(halt), .outputs_off_out(off),
    .enter_ok_out(enter_ok), .mem_wr_en_out(wr_en));
  rack_tape_model u_rack_tape_model (.clk_in(mclk_in), .rst_n_in(arst_n_in), .evt_in(evt),
    .corrupt_in(corrupt), .mute_in(mute), .ext_out(ext));
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // shown flag and code together
  task automatic ck(input logic [7:0] c);
    cmp({7'h00, err_show, err_code}, {7'h00, c != 8'h00, c});
  endtask
  // one-cycle key and partner pulses
  task automatic pulse(input logic [7:0] k, input logic [4:0] e);
    @(negedge mclk_in);
    key = k;
    evt = e;
    @(negedge mclk_in);
    key = '0;
    evt = 5'h00;
  endtask
  // enter run and feed a program whose last word holds the fault
  task automatic walk(input int kind, input int n, input logic [7:0] c);
    err_check_pkg::prog_word_t w;
    int i;
    mode = err_check_pkg::MODE_PROG;
    pulse(8'h80, 5'h00);
    mode = err_check_pkg::MODE_RUN;
    for (i = 0; i < 8 && scan_req !== 1'b1; i++) @(negedge mclk_in);
    if (scan_req !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    for (i = 0; i < n; i++) begin
      w = '0;
      w.valid = 1'b1;
      w.last = (i == n - 1);
      w.addr = 11'(i);
      w.is_start = (kind == 0 && i == 0);
      w.is_push = (kind == 0 && i > 0);
      w.is_coil = (kind == 1 || kind == 6);
      w.coil_ref = (kind == 1) ? 10'h005 : 10'(i);
      w.mc_end = (kind == 2);
      w.needs_preset = (kind == 3);
      w.rung_open = (kind == 4);
      w.parity_bad = (kind == 5);
      cmp({5'h00, scan_addr}, 16'(i));
      word = w;
      @(negedge mclk_in);
    end
    word = '0;
    ck(c);
    if (c != 8'h00) cmp({5'h00, err_addr}, 16'(n - 1));
  endtask
  task automatic t_ops;
    pulse(8'h40, 5'h00);
    cmp({15'h0000, enter_ok}, 16'h0001);
    pulse(8'h60, 5'h00);
    cmp({7'h00, enter_ok, err_code}, 16'h0001);
    pulse(8'h80, 5'h00);
    ck(8'h00);
    pulse(8'h44, 5'h00);
    ck(8'h11);
    cmp({15'h0000, enter_ok}, 16'h0000);
    pulse(8'h80, 5'h00);
    repeat (20) pulse(8'h02, 5'h00);
    ck(8'h00);
    pulse(8'h02, 5'h00);
    ck(8'h13);
    wrap = 1'b1;
    pulse(8'h81, 5'h00);
    ck(8'h99);
    repeat (5) @(negedge mclk_in);
    ck(8'h99);
    pulse(8'h44, 5'h00);
    ck(8'h11);
    hit = 1'b1;
    pulse(8'h81, 5'h00);
    ck(8'h00);
    mode = err_check_pkg::MODE_LOAD;
    pulse(8'h44, 5'h00);
    ck(8'h00);
  endtask
  task automatic t_load;
    repeat (3) pulse(8'h00, 5'h02);
    ck(8'h00);
    cmp({15'h0000, wr_en}, 16'h0000);
    cmp({5'h00, verify_addr}, 16'h0003);
    corrupt = 1'b1;
    pulse(8'h00, 5'h02);
    corrupt = 1'b0;
    ck(8'h25);
    pulse(8'h80, 5'h00);
    pulse(8'h00, 5'h01);
    ck(8'h28);
  endtask
  task automatic t_check;
    walk(0, 10, 8'h03);
    walk(1, 2, 8'h05);
    walk(2, 1, 8'h06);
    walk(3, 1, 8'h08);
    walk(4, 1, 8'h09);
    walk(5, 1, 8'h21);
    walk(6, 3, 8'h00);
    pulse(8'h08, 5'h00);
    ck(8'h01);
  endtask
  task automatic t_link;
    pulse(8'h00, 5'h08);
    ck(8'h31);
    cmp({14'h0000, halt, off}, 16'h0003);
    pulse(8'h00, 5'h04);
    ck(8'h32);
    mode = err_check_pkg::MODE_PROG;
    pulse(8'h00, 5'h10);
    ck(8'h30);
    cmp({14'h0000, halt, off}, 16'h0003);
    walk(6, 3, 8'h00);
    cmp({14'h0000, halt, off}, 16'h0000);
  endtask
  // mid-run reset in run with the rack silent: no-answer code at window end
  task automatic t_cfg;
    mute = 1'b1;
    mode = err_check_pkg::MODE_RUN;
    @(negedge mclk_in);
    arst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (19) @(negedge mclk_in);
    ck(8'h00);
    @(negedge mclk_in);
    ck(8'h33);
    cmp({14'h0000, halt, off}, 16'h0000);
  endtask
  // main sequence: reset, then each scenario
  initial begin
    repeat (16) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (30) @(negedge mclk_in);
    ck(8'h00);
    t_ops();
    t_load();
    t_check();
    t_link();
    t_cfg();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_errors++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
